/* pkg/lrs_params.svh */
// Constants for the terminal 16-47 line role select block
`ifndef LRS_PARAMS_SVH
`define LRS_PARAMS_SVH

`define LRS_OFF_ROLE_B   32'h0000_0000
`define LRS_OFF_ROLE_C   32'h0000_0004
`define LRS_OFF_STATUS   32'h0000_0008
`define LRS_ROLE_RESET   16'h0000
`define LRS_BANK_W       16
`define LRS_TERM_N       32
`define LRS_FIRST_TERM   16
`define LRS_PHASE_N      4
`define LRS_ROLE_SEGMENT 1'h0
`define LRS_ROLE_COMMON  1'h1
`define LRS_ACK_CYCLES   1

`endif

/* pkg/lrs_pkg.sv */
// Types for the terminal 16-47 line role select block
package lrs_pkg;
    typedef logic [15:0]  lrs_bank_t;
    typedef logic [31:0]  lrs_word_t;
    typedef logic [127:0] lrs_nib_t;

    typedef struct packed {
        lrs_bank_t role_b;
        lrs_bank_t role_c;
        logic      ack;
        lrs_word_t rdat;
        lrs_nib_t  seg;
        lrs_nib_t  com;
        lrs_word_t role;
    } lrs_state_t;
endpackage

/* pkg/lrs_decode_if.sv */
// Role and display memory lines between the register block and decoder
`timescale 1ns/1ps
`default_nettype none
interface lrs_decode_if;
    logic [31:0]  role;
    logic [127:0] mem;
    logic [127:0] seg;
    logic [127:0] com;

    modport regs (output role, output mem, input  seg, input  com);
    modport dec  (input  role, input  mem, output seg, output com);
endinterface
`default_nettype wire

/* rtl/lrs_role_decode.sv */
// Per-terminal split of display memory bits into segment or common use
`timescale 1ns/1ps
`default_nettype none
`include "lrs_params.svh"
module lrs_role_decode (
    lrs_decode_if.dec dif
);
    genvar t;
    generate
        for (t = 0; t < `LRS_TERM_N; t = t + 1) begin : g_term
            // RULE6 memory bit meaning
            assign dif.seg[4*t +: 4] = (dif.role[t] == `LRS_ROLE_SEGMENT)
                                     ? dif.mem[4*t +: 4] : 4'h0;
            assign dif.com[4*t +: 4] = (dif.role[t] == `LRS_ROLE_COMMON)
                                     ? dif.mem[4*t +: 4] : 4'h0;
        end
    endgenerate
endmodule
`default_nettype wire

/* rtl/lrs_top.sv */
// Line role select registers for display terminals 16 to 47
`timescale 1ns/1ps
`default_nettype none
`include "lrs_params.svh"
// What this block does
// RULE1: The first register holds terminals 16 to 31, bit 0 for 16 up to bit 15 for 31.
// RULE2: The second register holds terminals 32 to 47, bit 0 for 32 up to bit 15 for 47.
// RULE3: A role bit of zero makes the terminal a segment line, one a common line.
// RULE4: Reset clears every role bit so all terminals start as segment lines.
// RULE5: Software reads back every role bit exactly as it last wrote it.
// RULE6: Segment terminals show memory bits as on/off data, common ones as phases one to four.
module lrs_top (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [31:0]  wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    input  wire logic [127:0] mem_bits_i,
    output logic      [31:0]  role_o,
    output logic      [127:0] seg_on_o,
    output logic      [127:0] com_phase_o
);
    lrs_pkg::lrs_state_t state_reg;
    lrs_pkg::lrs_state_t state_next;
    lrs_decode_if        dif ();
    logic                take;
    logic [5:0]          com_count;

    lrs_role_decode u_dec (
        .dif (dif)
    );

    assign dif.role = {state_reg.role_c, state_reg.role_b};
    assign dif.mem  = mem_bits_i;

    // A new request is taken only while no answer is out, so one
    // access never acts twice on the same held request.
    assign take = wb_cyc_i && wb_stb_i && !state_reg.ack;

    always_comb begin
        com_count = 6'h00;
        for (int i = 0; i < `LRS_TERM_N; i++) begin
            com_count = com_count + {5'h00, dif.role[i]};
        end
    end

    always_comb begin
        state_next      = state_reg;
        state_next.ack  = take;
        // RULE6 registered split
        state_next.seg  = dif.seg;
        state_next.com  = dif.com;
        // RULE1 RULE2 linear terminal map
        state_next.role = dif.role;
        if (take && !wb_we_i) begin
            // RULE5 read back
            case (wb_adr_i)
                `LRS_OFF_ROLE_B: state_next.rdat = {16'h0000, state_reg.role_b};
                `LRS_OFF_ROLE_C: state_next.rdat = {16'h0000, state_reg.role_c};
                `LRS_OFF_STATUS: state_next.rdat = {16'h0000, 10'h000,
                                                    com_count};
                default:         state_next.rdat = 32'h0000_0000;
            endcase
        end else if (take) begin
            state_next.rdat = 32'h0000_0000;
        end
        if (take && wb_we_i) begin
            // RULE1 bank b write by lane
            if (wb_adr_i == `LRS_OFF_ROLE_B) begin
                if (wb_sel_i[0]) state_next.role_b[7:0]  = wb_dat_i[7:0];
                if (wb_sel_i[1]) state_next.role_b[15:8] = wb_dat_i[15:8];
            end
            // RULE2 bank c write by lane
            if (wb_adr_i == `LRS_OFF_ROLE_C) begin
                if (wb_sel_i[0]) state_next.role_c[7:0]  = wb_dat_i[7:0];
                if (wb_sel_i[1]) state_next.role_c[15:8] = wb_dat_i[15:8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // RULE4 all segment at reset
            state_reg        <= '0;
            state_reg.role_b <= `LRS_ROLE_RESET;
            state_reg.role_c <= `LRS_ROLE_RESET;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    assign wb_dat_o    = state_reg.rdat;
    assign wb_ack_o    = state_reg.ack;
    assign role_o      = state_reg.role;
    assign seg_on_o    = state_reg.seg;
    assign com_phase_o = state_reg.com;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ack_single_pulse: assert property ( // RULE5
        (ce_i && wb_ack_o) |=> !wb_ack_o)
        else $error("ack stayed high");

    chk_bank_b_write: assert property ( // RULE1
        (ce_i && take && wb_we_i && wb_adr_i == `LRS_OFF_ROLE_B
         && wb_sel_i[1:0] == 2'h3) ##1 ce_i
        |=> role_o[15:0] == $past(wb_dat_i[15:0], 2))
        else $error("bank b write not mapped to terminals 16-31");

    chk_bank_c_write: assert property ( // RULE2
        (ce_i && take && wb_we_i && wb_adr_i == `LRS_OFF_ROLE_C
         && wb_sel_i[1:0] == 2'h3) ##1 ce_i
        |=> role_o[31:16] == $past(wb_dat_i[15:0], 2))
        else $error("bank c write not mapped to terminals 32-47");

    chk_common_role_use: assert property ( // RULE3
        ce_i |=> com_phase_o[127:124] ==
            ($past(dif.role[31]) ? $past(mem_bits_i[127:124]) : 4'h0))
        else $error("terminal 47 common phase wrong");

    chk_reset_segment: assert property ( // RULE4
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> (state_reg.role_b == `LRS_ROLE_RESET
                   && state_reg.role_c == `LRS_ROLE_RESET && !wb_ack_o))
        else $error("role bits not cleared by reset");

    chk_read_returns_last: assert property ( // RULE5
        (ce_i && take && !wb_we_i && wb_adr_i == `LRS_OFF_ROLE_C)
        |=> wb_ack_o && wb_dat_o == {16'h0000, $past(state_reg.role_c)})
        else $error("read data differs from role bank c");

    chk_segment_data: assert property ( // RULE6
        ce_i |=> seg_on_o[3:0] ==
            ($past(dif.role[0]) ? 4'h0 : $past(mem_bits_i[3:0])))
        else $error("terminal 16 segment data wrong");

    chk_no_dual_role: assert property ( // RULE3
        (seg_on_o & com_phase_o) == 128'h0)
        else $error("memory bit used as segment and common at once");

    // A low enable must hold every registered output where it was
    chk_ce_freeze_all: assert property ( // RULE5
        !ce_i |=> $stable(wb_ack_o) && $stable(wb_dat_o)
                  && $stable(role_o) && $stable(seg_on_o)
                  && $stable(com_phase_o))
        else $error("state moved while clock enable was low");

    chk_ack_after_take: assert property ( // RULE5
        (ce_i && take) |=> wb_ack_o)
        else $error("taken request not answered next cycle");

    chk_no_ack_unasked: assert property ( // RULE5
        (ce_i && !take) |=> !wb_ack_o)
        else $error("answer given without a taken request");

    // Status counts common terminals from the banks themselves
    chk_status_count: assert property ( // RULE3
        (ce_i && take && !wb_we_i && wb_adr_i == `LRS_OFF_STATUS)
        |=> wb_dat_o == 32'($countones($past(dif.role))))
        else $error("status does not count common terminals");

    chk_bank_b_lane_low: assert property ( // RULE1
        (ce_i && take && wb_we_i && wb_adr_i == `LRS_OFF_ROLE_B
         && wb_sel_i[1:0] == 2'h1)
        |=> state_reg.role_b[7:0] == $past(wb_dat_i[7:0])
            && state_reg.role_b[15:8] == $past(state_reg.role_b[15:8]))
        else $error("byte lane write to bank b wrong");

    chk_bank_c_apart: assert property ( // RULE2
        (ce_i && take && wb_we_i && wb_adr_i == `LRS_OFF_ROLE_B)
        |=> $stable(state_reg.role_c))
        else $error("bank b write disturbed bank c");

    // Status and unmapped writes are ignored but still answered
    chk_stray_write_ignored: assert property ( // RULE5
        (ce_i && take && wb_we_i && wb_adr_i != `LRS_OFF_ROLE_B
         && wb_adr_i != `LRS_OFF_ROLE_C)
        |=> $stable(state_reg.role_b) && $stable(state_reg.role_c))
        else $error("stray write changed a role bank");

    chk_role_follows_bank: assert property ( // RULE1
        ce_i |=> role_o == $past(dif.role))
        else $error("role output does not follow the banks");

    chk_read_bank_b: assert property ( // RULE5
        (ce_i && take && !wb_we_i && wb_adr_i == `LRS_OFF_ROLE_B)
        |=> wb_ack_o && wb_dat_o == {16'h0000, $past(state_reg.role_b)})
        else $error("read data differs from role bank b");

    chk_write_dat_zero: assert property ( // RULE5
        (ce_i && take && wb_we_i) |=> wb_dat_o == 32'h0000_0000)
        else $error("write answer carried data");

    chk_seg_terminal_47: assert property ( // RULE6
        ce_i |=> seg_on_o[127:124] ==
            ($past(dif.role[31]) ? 4'h0 : $past(mem_bits_i[127:124])))
        else $error("terminal 47 segment data wrong");

    chk_com_terminal_16: assert property ( // RULE6
        ce_i |=> com_phase_o[3:0] ==
            ($past(dif.role[0]) ? $past(mem_bits_i[3:0]) : 4'h0))
        else $error("terminal 16 common phase wrong");
endmodule
`default_nettype wire

/* dv/lrs_glass_model.sv */
// Display memory source standing in for the glass electrodes
`timescale 1ns/1ps
`default_nettype none
module lrs_glass_model #(
    parameter logic [127:0] PATTERN = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
    input  wire logic [127:0] seg_i,
    input  wire logic [127:0] com_i,
    output logic      [127:0] mem_o,
    output logic              clash_o
);
    // Every nibble value appears, so each phase bit meets both roles
    assign mem_o   = PATTERN;
    // An electrode driven as segment and common at once is a clash
    assign clash_o = |(seg_i & com_i);
endmodule
`default_nettype wire

/* dv/lrs_top_test.sv */
// Register and decode test for the line role select block
`timescale 1ns/1ps
`default_nettype none
module lrs_top_test;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic         cyc = 1'b0;
    logic         we = 1'b0;
    logic [31:0]  adr = 32'h0;
    logic [31:0]  wdat = 32'h0;
    logic [31:0]  dat_o, rdat, role, a, d;
    logic         ack, clash;
    logic         ce = 1'b1;
    logic [3:0]   sel = 4'h3;
    logic [127:0] mem, seg, com, msk;
    logic [31:0]  exp_role = 32'h0;
    logic [31:0]  tbl [4] = '{32'h0000_8001, 32'h0004_8001,
                              32'h0000_5A3C, 32'h0004_FFFF};
    int           num_errors = 0;
    int           n_compared = 0;

    lrs_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .mem_bits_i(mem), .role_o(role),
        .seg_on_o(seg), .com_phase_o(com));
    lrs_glass_model i_glass (.seg_i(seg), .com_i(com), .mem_o(mem),
        .clash_o(clash));

    task automatic bus(input logic w, input logic [31:0] ba, bd);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= ba;
        wdat <= bd;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) num_errors++;
        rdat = dat_o;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Role and decode lag the bank, so let them settle first
    task automatic chk_lines();
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < 32; i++) msk[4*i +: 4] = {4{exp_role[i]}};
        chk(role, exp_role); // terminal map
        chk(seg, mem & ~msk); // segment data
        chk(com, mem & msk); // common phases
        chk(clash, 1'b0); // no electrode in both roles
    endtask

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, 32'h0, 32'h0);
        chk(rdat, 32'h0); // reset value
        bus(1'b0, 32'h4, 32'h0);
        chk(rdat, 32'h0); // reset value
        chk_lines();
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            a = {16'h0, tbl[k][31:16]};
            d = {16'h0, tbl[k][15:0]};
            bus(1'b1, a, d);
            if (a == 32'h4) exp_role[31:16] = d[15:0];
            else exp_role[15:0] = d[15:0];
            bus(1'b0, a, 32'h0);
            chk(rdat, d); // read back
            chk_lines();
            $display("test write %0d done", k);
        end
        // Unmapped write must leave both banks alone
        bus(1'b1, 32'hC, 32'hFFFF);
        bus(1'b0, 32'hC, 32'h0);
        chk(rdat, 32'h0); // unmapped reads zero
        chk_lines();
        $display("test unmapped done");
        bus(1'b0, 32'h8, 32'h0);
        chk(rdat, $countones(exp_role)); // common count
        sel <= 4'h1;
        bus(1'b1, 32'h0, 32'h00C3);
        sel <= 4'h3;
        exp_role[7:0] = 8'hC3;
        bus(1'b0, 32'h0, 32'h0);
        chk(rdat, {16'h0, exp_role[15:0]}); // low lane only
        chk_lines();
        $display("test status and lane done");
        ce <= 1'b0;
        cyc <= 1'b1;
        we <= 1'b1;
        adr <= 32'h4;
        wdat <= 32'h0;
        repeat (4) @(posedge clk_i);
        chk(ack, 1'b0); // no answer while frozen
        chk(role, exp_role); // banks frozen
        ce <= 1'b1;
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 1'b0;
        exp_role[31:16] = 16'h0;
        chk_lines();
        $display("test clock enable done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        exp_role = 32'h0;
        @(posedge clk_i);
        bus(1'b0, 32'h4, 32'h0);
        chk(rdat, 32'h0); // cleared again
        chk_lines();
        $display("test second reset done");
        stop_test();
    end
endmodule
`default_nettype wire
